// ---- src/peci_client.sv ----
// Client end: measures the first bit, decodes header bits, answers reply bits.
// Assumes the originator opens every bit with a rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "peci_timing_defines.svh"
module peci_client (
  input wire logic core_clk,
  input wire logic rst,
  peci_wire_if.client link,
  input wire logic [3:0] rxCount,
  input wire peci_timing_pkg::byte_t replyByte,
  output logic rxValid,
  output peci_timing_pkg::byte_t rxByte,
  output logic msgEnd
);
  import peci_timing_pkg::*;
  typedef struct packed {
    client_state_t st;
    count_t period;
    count_t cnt;
    count_t highCnt;
    logic prev;
    logic [2:0] bitIdx;
    logic [3:0] left;
    byte_t shift;
    logic drive;
    logic rxValid;
    byte_t rxByte;
    logic msgEnd;
  } cl_s_t;
  cl_s_t c_reg;
  cl_s_t c_next;
  logic w;
  wire_sync u_sync (.core_clk(core_clk), .rst(rst), .pinIn(link.wireLevel), .level(w));

  // Bit edge tracking; reply ones driven high right at the bit start
  always_comb begin
    c_next = c_reg;
    c_next.rxValid = 1'b0;
    c_next.msgEnd = 1'b0;
    c_next.prev = w;
    c_next.cnt = (c_reg.cnt == 16'hffff) ? c_reg.cnt : c_reg.cnt + 16'h1;
    if (w) begin
      c_next.highCnt = c_reg.highCnt + 16'h1;
    end
    if (w && !c_reg.prev) begin // RL10
      c_next.cnt = 16'h0000;
      c_next.highCnt = 16'h0000;
      if (c_reg.st == C_IDLE) begin
        c_next.st = C_RX;
        c_next.period = 16'h0000;
        c_next.bitIdx = 3'h7;
        c_next.left = rxCount;
      end else begin
        if (c_reg.period == 16'h0000) begin
          c_next.period = c_reg.cnt + 16'h1; // RL13
        end
        if (c_reg.st == C_RX) begin
          c_next.shift = {c_reg.shift[6:0], (c_reg.highCnt > (c_reg.cnt >> 1)) ? 1'b1 : 1'b0};
          c_next.bitIdx = c_reg.bitIdx - 3'h1;
          if (c_reg.bitIdx == 3'h0) begin
            c_next.rxValid = 1'b1;
            c_next.rxByte = c_next.shift;
            c_next.left = c_reg.left - 4'h1;
            if (c_reg.left == 4'h1) begin
              c_next.st = C_TX;
              c_next.shift = replyByte;
              // First reply bit rides on this same opening edge
              c_next.drive = replyByte[7]; // RL11
            end
          end
        end else begin
          c_next.bitIdx = c_reg.bitIdx - 3'h1;
          c_next.drive = c_reg.shift[c_reg.bitIdx - 3'h1]; // RL11
        end
      end
    end
    // Release at 3/4 period from the wire rise, net of sync and edge lag
    if (c_reg.st == C_TX
        && c_reg.cnt == ((c_reg.period >> 2) * 16'h3) - 16'(`CLIENT_RISE_LAT_CYC)) begin // RL2
      c_next.drive = 1'b0;
    end
    // Message end: two periods without any rising edge
    if (c_reg.st != C_IDLE && c_reg.period != 16'h0000
        && c_reg.cnt > {c_reg.period[14:0], 1'b0}) begin // RL5
      c_next.st = C_IDLE;
      c_next.drive = 1'b0;
      c_next.msgEnd = 1'b1;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      c_reg <= '0;
    end else begin
      c_reg <= c_next;
    end
  end
  assign link.clientOut = c_reg.drive;
  assign link.clientOe = c_reg.drive;
  assign rxValid = c_reg.rxValid;
  assign rxByte = c_reg.rxByte;
  assign msgEnd = c_reg.msgEnd;
endmodule // peci_client
`default_nettype wire

// ---- src/peci_originator.sv ----
// Originator end: sends a header byte train, reads reply bytes, ends with stop.
// Assumes the interface resolves the wire; user side is a simple request port.
//
// Rules for both ends of the link
// (RL1) Driven bit period within 0.495 to 250 us
// (RL2) One bit: high 0.6-0.8 period, nominal 0.75
// (RL3) Zero bit: high 0.2-0.4 period, nominal 0.3
// (RL4) Message ends with two-period low stop
// (RL5) End seen after two edgeless bit periods
// (RL6) Pre-message low two periods, else 1 ms
// (RL7) Stop low also counts as setup low
// (RL8) Client reset dwell 0.4 ms before readdressing
// (RL9) Client idle drive at most half period
// (RL10) Client may release on qualified opening edge
// (RL11) Client one drives high by 0.2 period
// (RL12) Bit periods stable within one message
// (RL13) Limits refer to negotiated bit period
// (RL14) Originator issues every transmission on wire
// (RL15) Receive bit is one above half period
// (RL16) Measure period across negotiation pulse, derive counts
`timescale 1ns/1ps
`default_nettype none
`include "peci_timing_defines.svh"
module peci_originator (
  input wire logic core_clk,
  input wire logic rst,
  peci_wire_if.originator link,
  input wire logic start,
  input wire peci_timing_pkg::count_t bitPeriod,
  input wire peci_timing_pkg::byte_t txByte,
  input wire logic [3:0] txCount,
  input wire logic [3:0] rxCount,
  input wire logic resetDevice,
  output logic busy,
  output logic rxValid,
  output peci_timing_pkg::byte_t rxByte,
  output logic txTake,
  output logic done,
  output peci_timing_pkg::count_t measuredPeriod
);
  import peci_timing_pkg::*;

  // Fraction of a period, rounded down; used for every high time
  function automatic count_t frac(input count_t p, input logic [3:0] num, input logic [3:0] den);
    logic [19:0] prod;
    prod = {4'h0, p} * {16'h0000, num};
    frac = count_t'(prod / {16'h0000, den});
  endfunction

  // Clamp a requested period into the driven range
  function automatic count_t clampPeriod(input count_t p);
    if (p < count_t'(`BIT_PERIOD_MIN_CYC)) begin
      clampPeriod = count_t'(`BIT_PERIOD_MIN_CYC);
    end else if ({16'h0000, p} > 32'(`BIT_PERIOD_MAX_CYC)) begin
      clampPeriod = count_t'(`BIT_PERIOD_MAX_CYC);
    end else begin
      clampPeriod = p;
    end
  endfunction

  typedef struct packed {
    orig_state_t st;
    count_t period;
    count_t cnt;
    logic [31:0] lowCnt;
    logic periodKnown;
    logic [31:0] dwell;
    logic [2:0] bitIdx;
    logic [3:0] bytesLeft;
    logic [3:0] rxLeft;
    byte_t shift;
    logic firstBit;
    logic sawHigh;
    count_t highCnt;
    logic drive;
    logic busy;
    logic rxValid;
    byte_t rxByte;
    logic txTake;
    logic done;
    count_t measured;
  } orig_s_t;
  orig_s_t r_reg;
  orig_s_t r_next;
  logic wireSync;

  wire_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn(link.wireLevel),
    .level(wireSync)
  );

  // Whole bit engine; one period fixed per message keeps jitter and drift at zero
  always_comb begin
    r_next = r_reg;
    r_next.rxValid = 1'b0;
    r_next.txTake = 1'b0;
    r_next.done = 1'b0;
    if (r_reg.dwell != 32'h0) begin
      r_next.dwell = r_reg.dwell - 32'h1; // RL8
    end
    // Low time seen on the wire; stop low counts toward setup
    if (wireSync) begin
      r_next.lowCnt = 32'h0;
    end else if (r_reg.lowCnt != 32'hffffffff) begin
      r_next.lowCnt = r_reg.lowCnt + 32'h1; // RL7
    end
    case (r_reg.st)
      O_IDLE: begin
        r_next.drive = 1'b0;
        if (start && !r_reg.busy) begin
          r_next.busy = 1'b1;
          r_next.st = O_SETUP;
        end
      end
      O_SETUP: begin
        // Unknown previous period assumes the 1 ms worst case
        if ((r_reg.periodKnown && r_reg.lowCnt >= {15'h0, r_reg.period, 1'b0})
            || (!r_reg.periodKnown && r_reg.lowCnt >= 32'(`SETUP_UNKNOWN_CYC))) begin // RL6
          if (r_reg.dwell == 32'h0) begin // RL8
            r_next.period = clampPeriod(bitPeriod); // RL1 RL12
            r_next.periodKnown = 1'b1;
            r_next.st = O_TX; // RL14
            r_next.cnt = 16'h0000;
            r_next.bitIdx = 3'h7;
            r_next.bytesLeft = txCount;
            r_next.rxLeft = rxCount;
            r_next.shift = 8'h00;
            r_next.firstBit = 1'b1;
            r_next.txTake = 1'b1;
            r_next.shift = txByte;
          end
        end
      end
      O_TX: begin
        // Each bit opens high; the high share encodes the value
        r_next.cnt = r_reg.cnt + 16'h1;
        if (r_reg.cnt < frac(r_reg.period, r_reg.shift[r_reg.bitIdx] ? 4'd3 : 4'd3,
                             r_reg.shift[r_reg.bitIdx] ? 4'd4 : 4'd10)) begin
          r_next.drive = 1'b1; // RL2 RL3
        end else begin
          r_next.drive = 1'b0;
        end
        if (r_reg.cnt == r_reg.period - 16'h1) begin
          r_next.cnt = 16'h0000;
          if (r_reg.firstBit) begin
            r_next.measured = r_reg.period; // RL16
          end
          r_next.firstBit = 1'b0;
          if (r_reg.bitIdx != 3'h0) begin
            r_next.bitIdx = r_reg.bitIdx - 3'h1;
          end else if (r_reg.bytesLeft > 4'h1) begin
            r_next.bytesLeft = r_reg.bytesLeft - 4'h1;
            r_next.bitIdx = 3'h7;
            r_next.shift = txByte;
            r_next.txTake = 1'b1;
          end else if (r_reg.rxLeft != 4'h0) begin
            r_next.st = O_RX;
            r_next.bitIdx = 3'h7;
            r_next.sawHigh = 1'b0;
            r_next.highCnt = 16'h0000;
          end else begin
            r_next.st = O_STOP;
          end
        end
      end
      O_RX: begin
        // Opening lasts a zero's high time; it must overlap the client's late
        // rise for a one, or the wire dips and shows a false bit edge
        r_next.cnt = r_reg.cnt + 16'h1;
        r_next.drive = (r_reg.cnt < frac(r_reg.period, 4'd3, 4'd10)) ? 1'b1 : 1'b0; // RL3 RL13
        if (wireSync) begin
          r_next.highCnt = r_reg.highCnt + 16'h1;
        end
        if (r_reg.cnt == r_reg.period - 16'h1) begin
          r_next.cnt = 16'h0000;
          r_next.highCnt = 16'h0000;
          r_next.shift = {r_reg.shift[6:0],
            (r_reg.highCnt > frac(r_reg.period, 4'd1, 4'd2)) ? 1'b1 : 1'b0}; // RL15
          if (r_reg.bitIdx != 3'h0) begin
            r_next.bitIdx = r_reg.bitIdx - 3'h1;
          end else begin
            r_next.rxValid = 1'b1;
            r_next.rxByte = {r_reg.shift[6:0],
              (r_reg.highCnt > frac(r_reg.period, 4'd1, 4'd2)) ? 1'b1 : 1'b0};
            r_next.bitIdx = 3'h7;
            if (r_reg.rxLeft == 4'h1) begin
              r_next.st = O_STOP;
            end
            r_next.rxLeft = r_reg.rxLeft - 4'h1;
          end
        end
      end
      O_STOP: begin
        // Two full periods of constant low close the message
        r_next.drive = 1'b0;
        r_next.cnt = r_reg.cnt + 16'h1;
        if ({16'h0000, r_reg.cnt} == {15'h0, r_reg.period, 1'b0} - 32'h1) begin // RL4 RL5
          r_next.st = O_IDLE;
          r_next.busy = 1'b0;
          r_next.done = 1'b1;
          r_next.cnt = 16'h0000;
          if (resetDevice) begin
            r_next.dwell = 32'(`CLIENT_RESET_DWELL_CYC); // RL8
          end
        end
      end
      default: begin
        r_next.st = O_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Wire driven only while sending a high slice
  assign link.origOut = r_reg.drive;
  assign link.origOe = r_reg.drive;
  assign busy = r_reg.busy;
  assign rxValid = r_reg.rxValid;
  assign rxByte = r_reg.rxByte;
  assign txTake = r_reg.txTake;
  assign done = r_reg.done;
  assign measuredPeriod = r_reg.measured;
endmodule // peci_originator
`default_nettype wire

// ---- src/peci_timing_defines.svh ----
// Timing constants for the single-wire originator link.
// Assumes a 40 MHz core clock; included by the package and modules.
`ifndef PECI_TIMING_DEFINES_SVH
`define PECI_TIMING_DEFINES_SVH

`define CORE_CLK_MHZ 40
// Bit period driven by the originator, in ns and as cycles
`define BIT_PERIOD_MIN_NS 495
`define BIT_PERIOD_MAX_NS 250000
`define BIT_PERIOD_MIN_CYC ((`BIT_PERIOD_MIN_NS * `CORE_CLK_MHZ + 999) / 1000)
`define BIT_PERIOD_MAX_CYC ((`BIT_PERIOD_MAX_NS * `CORE_CLK_MHZ) / 1000)
// Default bit period in cycles (2 us)
`define BIT_PERIOD_DEF_CYC 16'h0050
// Setup wait when the previous bit period is unknown, in us
`define SETUP_UNKNOWN_US 1000
`define SETUP_UNKNOWN_CYC (`SETUP_UNKNOWN_US * `CORE_CLK_MHZ)
// Client reset dwell, in us
`define CLIENT_RESET_DWELL_US 400
`define CLIENT_RESET_DWELL_CYC (`CLIENT_RESET_DWELL_US * `CORE_CLK_MHZ)
// Client noise qualification for the opening edge, cycles
`define CLIENT_EDGE_QUAL_CYC 4
// Client lag from a wire rise to its first count of the bit, cycles
`define CLIENT_RISE_LAT_CYC 6
// Bit-time counter width
`define CNT_W 16
`define BYTE_W 8

`endif

// ---- src/peci_timing_pkg.sv ----
// Types shared by both ends of the single-wire link.
// Assumes peci_timing_defines.svh sits on the include path.
`include "peci_timing_defines.svh"
package peci_timing_pkg;
  typedef logic [`CNT_W-1:0] count_t;
  typedef logic [`BYTE_W-1:0] byte_t;
  typedef enum logic [2:0] {
    O_IDLE = 3'b000,
    O_SETUP = 3'b001,
    O_TX = 3'b010,
    O_RX = 3'b011,
    O_STOP = 3'b100
  } orig_state_t;
  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_RX = 2'b01,
    C_TX = 2'b10
  } client_state_t;
endpackage

// ---- src/peci_wire_if.sv ----
// Shared single wire between the originator and one client model end.
// Assumes open-drain style resolution: the wire is high when either drives high.
`timescale 1ns/1ps
`default_nettype none
interface peci_wire_if;
  logic origOut;
  logic origOe;
  logic clientOut;
  logic clientOe;
  logic wireLevel;
  // Either end driving high lifts the wire; otherwise weakly low
  assign wireLevel = (origOe & origOut) | (clientOe & clientOut);
  modport originator (output origOut, output origOe, input wireLevel);
  modport client (output clientOut, output clientOe, input wireLevel);
endinterface // peci_wire_if
`default_nettype wire

// ---- src/wire_sync.sv ----
// Three-stage synchroniser with agreement of the last two stages.
// Assumes an asynchronous input and one core clock.
`timescale 1ns/1ps
`default_nettype none
module wire_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic level
);
  typedef struct packed {
    logic [2:0] stages;
    logic level;
  } sync_state_t;
  sync_state_t s_reg;
  sync_state_t s_next;
  // Output changes only when stages two and three agree
  always_comb begin
    s_next = s_reg;
    s_next.stages = {s_reg.stages[1:0], pinIn};
    if (s_reg.stages[1] == s_reg.stages[2]) begin
      s_next.level = s_reg.stages[2];
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign level = s_reg.level;
endmodule // wire_sync
`default_nettype wire

// ---- test/peci_link_checker.sv ----
// Wire checks for the single-wire link between originator and client.
// Assumes one core clock and a bit period fixed at BIT_CYC by the bench.
`timescale 1ns/1ps
`default_nettype none
module peci_link_checker #(
  parameter int BIT_CYC = 20
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic origOut,
  input wire logic origOe,
  input wire logic clientOut,
  input wire logic clientOe,
  input wire logic wireLevel
);
  localparam int UNKNOWN_SETUP = 40000;
  localparam int HI_MAX = BIT_CYC * 4 / 5;
  logic origDrive;
  logic clientDrive;
  logic seen_reg;
  logic [15:0] lowCnt_reg;
  logic [15:0] hiCnt_reg;
  logic [15:0] gap_reg;
  assign origDrive = origOe & origOut;
  assign clientDrive = clientOe & clientOut;
  // Low run counts from reset, so the first setup is really measured
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seen_reg <= 1'b0;
      lowCnt_reg <= 16'h0000;
      hiCnt_reg <= 16'h0000;
      gap_reg <= 16'hffff;
    end else begin
      seen_reg <= seen_reg | wireLevel;
      lowCnt_reg <= wireLevel ? 16'h0000 : lowCnt_reg + {15'h0000, lowCnt_reg != 16'hffff};
      hiCnt_reg <= origDrive ? hiCnt_reg + 16'h0001 : 16'h0000;
      gap_reg <= $rose(origDrive) ? 16'h0001 : gap_reg + {15'h0000, gap_reg != 16'hffff};
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence bitStart;
    $rose(origDrive);
  endsequence
  sequence wireStart;
    $rose(wireLevel);
  endsequence
  a_first_setup: assert property ($rose(wireLevel) && !seen_reg |-> lowCnt_reg >= UNKNOWN_SETUP - 4)
    else $error("first message opened before the long setup");
  a_stop_gap: assert property (wireStart |-> lowCnt_reg < BIT_CYC || lowCnt_reg >= 2 * BIT_CYC)
    else $error("low stretch before a rise is neither a bit gap nor a stop");
  a_bit_spacing: assert property (bitStart |-> gap_reg == BIT_CYC || gap_reg > 2 * BIT_CYC)
    else $error("bit period not steady");
  a_high_cap: assert property (wireStart |-> ##[1:HI_MAX] !wireLevel)
    else $error("wire held high past the longest one");
  a_pulse_len: assert property ($fell(origDrive) |-> hiCnt_reg inside
    {[BIT_CYC / 5:BIT_CYC * 2 / 5], [BIT_CYC * 3 / 5:HI_MAX]})
    else $error("originator high time outside the bit windows");
  a_rise_owner: assert property (wireStart |-> origDrive)
    else $error("wire raised by the client");
  a_client_prompt: assert property ($rose(clientDrive) |-> gap_reg <= BIT_CYC / 5 + 1)
    else $error("client raised a one too late");
  a_client_window: assert property (clientDrive |-> gap_reg < BIT_CYC)
    else $error("client drove outside an opened bit");
endmodule // peci_link_checker
`default_nettype wire

// ---- test/test_peci_originator_bit_timing.sv ----
// Bench joining originator and client through one shared wire.
// Assumes a 40 MHz core clock and a bit period of 20 cycles.
`timescale 1ns/1ps
`default_nettype none
module test_peci_originator_bit_timing;
  import peci_timing_pkg::*;
  localparam int BIT_CYC = 20;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic start = 1'b0;
  logic resetDevice = 1'b0;
  count_t bitPeriod = 16'h0014;
  byte_t txByte = 8'h00;
  byte_t tx1 = 8'h00;
  byte_t replyByte = 8'h00;
  logic [3:0] txCount = 4'h2;
  logic [3:0] oRxCount = 4'h1;
  logic busy, oRxValid, txTake, done, cRxValid, msgEnd;
  byte_t oRxByte, cRxByte;
  count_t measuredPeriod;
  int fails = 0;
  int num_checks = 0;
  int doneCnt, endCnt, lowRun, msgLow;
  byte_t cQ[$];
  byte_t oQ[$];
  peci_wire_if link();
  peci_originator i_peci_originator(.core_clk(core_clk), .rst(rst), .link(link.originator),
    .start(start), .bitPeriod(bitPeriod), .txByte(txByte), .txCount(txCount),
    .rxCount(oRxCount), .resetDevice(resetDevice), .busy(busy), .rxValid(oRxValid),
    .rxByte(oRxByte), .txTake(txTake), .done(done), .measuredPeriod(measuredPeriod));
  peci_client i_peci_client(.core_clk(core_clk), .rst(rst), .link(link.client),
    .rxCount(txCount), .replyByte(replyByte), .rxValid(cRxValid), .rxByte(cRxByte),
    .msgEnd(msgEnd));
  peci_link_checker #(.BIT_CYC(BIT_CYC)) i_peci_link_checker(.core_clk(core_clk), .rst(rst),
    .origOut(link.origOut), .origOe(link.origOe), .clientOut(link.clientOut),
    .clientOe(link.clientOe), .wireLevel(link.wireLevel));
  always #12.5 core_clk = ~core_clk;
  // Low run before each message start, pulse counts and received bytes
  always @(posedge core_clk) begin
    lowRun <= link.wireLevel ? 0 : lowRun + 1;
    if (link.wireLevel && lowRun >= 2 * BIT_CYC) msgLow <= lowRun;
    if (done) doneCnt <= doneCnt + 1;
    if (msgEnd) endCnt <= endCnt + 1;
    if (cRxValid) cQ.push_back(cRxByte);
    if (oRxValid) oQ.push_back(oRxByte);
    if (txTake) txByte <= tx1;
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Start is held until the wire opens, since a dwell may delay it
  task automatic run_msg(input byte_t b0, input byte_t b1, input byte_t rep, input logic rd);
    int n;
    @(posedge core_clk);
    txByte <= b0;
    tx1 <= b1;
    replyByte <= rep;
    resetDevice <= rd;
    cQ.delete();
    oQ.delete();
    doneCnt <= 0;
    endCnt <= 0;
    start <= 1'b1;
    n = 0;
    while (link.wireLevel !== 1'b1 && n < 50000) begin
      @(posedge core_clk);
      n++;
    end
    check("busy while sending", 16'h0001, {15'h0000, busy});
    start <= 1'b0;
    repeat (30) @(posedge core_clk);
    start <= 1'b1;
    @(posedge core_clk);
    start <= 1'b0;
    while (doneCnt == 0 && n < 50000) begin
      @(posedge core_clk);
      n++;
    end
    repeat (4) @(posedge core_clk);
    check("message time", 16'h0001, 16'(n < 50000));
    check("idle after done", 16'h0000, {15'h0000, busy});
  endtask
  task automatic test_first();
    run_msg(8'ha5, 8'h3c, 8'h96, 1'b0);
    check("long setup", 16'h0001, 16'(msgLow >= 40000));
    check("client byte 0", 16'h00a5, {8'h00, cQ[0]});
    check("client byte 1", 16'h003c, {8'h00, cQ[1]});
    check("reply byte", 16'h0096, {8'h00, oQ[0]});
    check("measured period", 16'h0014, measuredPeriod);
    check("done count", 16'h0001, 16'(doneCnt));
    check("end count", 16'h0001, 16'(endCnt));
    $display("test_first finished");
  endtask
  task automatic test_back();
    run_msg(8'h00, 8'hff, 8'h01, 1'b0);
    check("overlapped setup", 16'h0001, 16'(msgLow >= 40 && msgLow < 80));
    check("client byte 0", 16'h0000, {8'h00, cQ[0]});
    check("client byte 1", 16'h00ff, {8'h00, cQ[1]});
    check("reply byte", 16'h0001, {8'h00, oQ[0]});
    $display("test_back finished");
  endtask
  task automatic test_dwell();
    run_msg(8'h5a, 8'hc3, 8'h80, 1'b1);
    run_msg(8'h0f, 8'hf0, 8'h7e, 1'b0);
    check("reset dwell", 16'h0001, 16'(msgLow >= 16000));
    check("client byte 0", 16'h000f, {8'h00, cQ[0]});
    check("reply byte", 16'h007e, {8'h00, oQ[0]});
    $display("test_dwell finished");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    test_first();
    test_back();
    test_dwell();
    end_sim();
  end
  // Tests need about 60000 cycles
  initial begin
    repeat (90000) @(posedge core_clk);
    fails++;
    end_sim();
  end
endmodule // test_peci_originator_bit_timing
`default_nettype wire
